// File: hdl/bbml_core.sv
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "bbml_cfg.svh"

module bbml_core
(
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // register port
   input wire logic [`BBML_ADDR_W-1:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // configuration switches
   input wire logic [`BBML_WIN_W-1:0] win_sw_i,
   // rom window decode
   output logic [`BBML_WIN_W-1:0] rom_window_o,
   output logic rom_bank_o,
   // mailbox gate
   output logic mbox_init_en_o,
   output logic mbox_init_o,
   // interrupt
   output logic irq_o
);

   ////////////////////////////////////////////////////////////////////////
   // state

   bbml_pkg::bbml_state_t state;
   bbml_pkg::bbml_state_t next_state;
   logic [7:0] param0;
   logic param_cnt;
   logic [7:0] lock_code;
   logic [7:0] din_byte;
   logic din_full;
   logic [7:0] int_flag;
   logic [7:0] int_mask;
   logic ext_xlat;
   logic [`BBML_WIN_W-1:0] sw_meta;
   logic [`BBML_WIN_W-1:0] sw_sync;

   ////////////////////////////////////////////////////////////////////////
   // decode

   function automatic logic hit(input logic [`BBML_ADDR_W-1:0] a,
                                input logic [`BBML_ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   wire cmd_wr = wr_i && hit(addr_i, `BBML_OFS_CMD_OUT);
   wire flag_wr = wr_i && hit(addr_i, `BBML_OFS_INT_FLAG);
   wire mask_wr = wr_i && hit(addr_i, `BBML_OFS_INT_MASK);
   wire cfg_wr = wr_i && hit(addr_i, `BBML_OFS_CONFIG);
   wire din_rd = rd_i && hit(addr_i, `BBML_OFS_DATA_IN);
   wire is_idle = (state == bbml_pkg::BBML_IDLE);
   wire locked = (lock_code != 8'h00);

   // opcode byte accepted only while idle
   wire op_take = cmd_wr && is_idle;
   wire op_b1 = op_take && (wdata_i == `BBML_OP_BANK_ONE);
   wire op_b2 = op_take && (wdata_i == `BBML_OP_BANK_TWO);
   wire op_info = op_take && (wdata_i == `BBML_OP_EXT_INFO);
   wire op_lock = op_take && (wdata_i == `BBML_OP_MBOX_EN);
   wire op_init = op_take && (wdata_i == `BBML_OP_MBOX_INIT);
   wire init_ok = op_init && !locked;
   wire op_bad = op_take && !(op_b1 || op_b2 || op_info || op_lock || init_ok);

   wire par_last = cmd_wr && (state == bbml_pkg::BBML_PARAM) && param_cnt;
   wire do_lock = par_last && param0[0];
   wire do_unlock = par_last && !param0[0] && (wdata_i == lock_code);
   wire info_done = din_rd && (state == bbml_pkg::BBML_SEND1) && din_full;

   wire [7:0] info0 = {4'h0, ext_xlat, 3'h0};
   wire [7:0] info1 = lock_code;

   ////////////////////////////////////////////////////////////////////////
   // events into the interrupt flag register

   wire quiet_done = op_b1 || op_b2;
   wire loud_done = par_last || info_done || init_ok;
   wire [7:0] ev;
   assign ev[`BBML_IF_CMD_DONE] = quiet_done || loud_done;
   assign ev[`BBML_IF_INVALID] = op_bad;
   assign ev[`BBML_IF_MBOX_INIT] = init_ok;
   assign ev[6:3] = 4'h0;
   assign ev[`BBML_IF_ANY] = loud_done || op_bad;

   // set wins over a same-cycle clear
   wire [7:0] clr = flag_wr ? wdata_i : 8'h00;
   wire [7:0] next_int_flag = (int_flag & ~clr) | ev;
   wire next_irq = next_int_flag[`BBML_IF_ANY] &&
                   ((next_int_flag[6:0] & int_mask[6:0]) != 7'h00);

   ////////////////////////////////////////////////////////////////////////
   // read mux

   wire [7:0] status = {5'h00, is_idle, !is_idle, din_full};
   wire [7:0] state_rd = {5'h00, locked, rom_bank_o, ext_xlat};
   logic [7:0] rd_mux;
   always_comb
   begin
      case (addr_i)
         `BBML_OFS_DATA_IN: rd_mux = din_byte;
         `BBML_OFS_STATUS: rd_mux = status;
         `BBML_OFS_INT_FLAG: rd_mux = int_flag;
         `BBML_OFS_INT_MASK: rd_mux = int_mask;
         `BBML_OFS_CONFIG: rd_mux = {7'h00, ext_xlat};
         `BBML_OFS_STATE: rd_mux = state_rd;
         default: rd_mux = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // command sequencer

   always_comb
   begin
      next_state = state;
      case (state)
         bbml_pkg::BBML_IDLE:
         begin
            if (op_lock)
               next_state = bbml_pkg::BBML_PARAM;
            else if (op_info)
               next_state = bbml_pkg::BBML_SEND0;
         end
         bbml_pkg::BBML_PARAM:
         begin
            if (par_last)
               next_state = bbml_pkg::BBML_IDLE;
         end
         bbml_pkg::BBML_SEND0:
         begin
            if (din_rd && din_full)
               next_state = bbml_pkg::BBML_SEND1;
         end
         bbml_pkg::BBML_SEND1:
         begin
            if (info_done)
               next_state = bbml_pkg::BBML_IDLE;
         end
         default: next_state = bbml_pkg::BBML_IDLE;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         state <= bbml_pkg::BBML_IDLE;
         param_cnt <= 1'b0;
         param0 <= 8'h00;
      end
      else
      begin
         state <= next_state;
         if (op_lock)
            param_cnt <= 1'b0;
         else if (cmd_wr && state == bbml_pkg::BBML_PARAM)
         begin
            param_cnt <= 1'b1;
            if (!param_cnt)
               param0 <= wdata_i;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // data-in port

   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         din_byte <= 8'h00;
         din_full <= 1'b0;
      end
      else if (op_info)
      begin
         din_byte <= info0;
         din_full <= 1'b1;
      end
      else if (din_rd && din_full && state == bbml_pkg::BBML_SEND0)
      begin
         din_byte <= info1;
         din_full <= 1'b1;
      end
      else if (din_rd)
         din_full <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // bank, lock, config

   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         rom_bank_o <= `BBML_RST_BANK;
         lock_code <= `BBML_RST_LOCK;
         ext_xlat <= `BBML_RST_CONFIG;
      end
      else
      begin
         if (op_b1)
            rom_bank_o <= 1'b0;
         else if (op_b2)
            rom_bank_o <= 1'b1;
         // zero code would read back as unlocked, so the host avoids it
         if (do_lock)
            lock_code <= wdata_i;
         else if (do_unlock)
            lock_code <= 8'h00;
         if (cfg_wr)
            ext_xlat <= wdata_i[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // switch window, three-stage synchroniser

   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         sw_meta <= '0;
         sw_sync <= '0;
         rom_window_o <= '0;
      end
      else
      begin
         sw_meta <= win_sw_i;
         sw_sync <= sw_meta;
         rom_window_o <= sw_sync;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupt flags, mask, bus read, outputs

   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         int_flag <= 8'h00;
         int_mask <= `BBML_RST_MASK;
         irq_o <= 1'b0;
         rdata_o <= 8'h00;
         mbox_init_en_o <= 1'b1;
         mbox_init_o <= 1'b0;
      end
      else
      begin
         int_flag <= next_int_flag;
         if (mask_wr)
            int_mask <= wdata_i;
         irq_o <= next_irq;
         rdata_o <= rd_i ? rd_mux : 8'h00;
         mbox_init_en_o <= (do_lock) ? 1'b0 :
                           (do_unlock) ? 1'b1 : mbox_init_en_o;
         mbox_init_o <= init_ok;
      end
   end

endmodule : bbml_core
`default_nettype wire

// File: hdl/bbml_cfg.svh
`ifndef BBML_CFG_SVH
`define BBML_CFG_SVH

// register byte offsets
`define BBML_ADDR_W 8
`define BBML_OFS_CMD_OUT 8'h00
`define BBML_OFS_DATA_IN 8'h04
`define BBML_OFS_STATUS 8'h08
`define BBML_OFS_INT_FLAG 8'h0C
`define BBML_OFS_INT_MASK 8'h10
`define BBML_OFS_CONFIG 8'h14
`define BBML_OFS_STATE 8'h18

// opcodes
`define BBML_OP_MBOX_INIT 8'h01
`define BBML_OP_BANK_ONE 8'h26
`define BBML_OP_BANK_TWO 8'h27
`define BBML_OP_EXT_INFO 8'h28
`define BBML_OP_MBOX_EN 8'h29

// interrupt flag register fields
`define BBML_IF_CMD_DONE 0
`define BBML_IF_INVALID 1
`define BBML_IF_MBOX_INIT 2
`define BBML_IF_ANY 7

// status register fields
`define BBML_ST_DIN_FULL 0
`define BBML_ST_BUSY 1
`define BBML_ST_IDLE 2

// result byte 0 field
`define BBML_EXT_XLAT_BIT 3

// switch window selector width and reset values
`define BBML_WIN_W 3
`define BBML_RST_BANK 1'b0
`define BBML_RST_LOCK 8'h00
`define BBML_RST_MASK 8'h00
`define BBML_RST_CONFIG 1'b0

`endif

// File: hdl/bbml_pkg.sv
package bbml_pkg;

   typedef enum logic [1:0] {
      BBML_IDLE,
      BBML_PARAM,
      BBML_SEND0,
      BBML_SEND1
   } bbml_state_t;

endpackage : bbml_pkg

// File: bench/bbml_rom_map.sv
`timescale 1ns/10ps
`default_nettype none
module bbml_rom_map
(
   // decode inputs
   input wire logic bank_i,
   input wire logic [13:0] offset_i,
   // rom address
   output logic [14:0] rom_addr_o
);
   assign rom_addr_o = {bank_i, offset_i};
endmodule : bbml_rom_map
`default_nettype wire

// File: bench/bbml_core_sva.sv
`timescale 1ns/10ps
`default_nettype none
module bbml_core_chk
(
   // watched ports
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic [2:0] win_sw_i,
   input wire logic [2:0] rom_window_o,
   input wire logic rom_bank_o,
   input wire logic mbox_init_en_o,
   input wire logic mbox_init_o,
   input wire logic irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   logic [1:0] pend;
   logic [1:0] sends;
   logic lk;
   logic [7:0] code;
   wire logic wc = wr_i && addr_i == 8'h00;
   wire logic idle = pend == 2'h0 && sends == 2'h0;
   // parameter bytes would look like opcodes
   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         pend <= 2'h0;
         sends <= 2'h0;
      end
      else
      begin
         if (wc && idle && wdata_i == 8'h29)
            pend <= 2'h2;
         else if (wc && pend != 2'h0)
            pend <= pend - 2'h1;
         if (wc && idle && wdata_i == 8'h28)
            sends <= 2'h2;
         else if (rd_i && addr_i == 8'h04 && sends != 2'h0)
            sends <= sends - 2'h1;
         if (wc && pend == 2'h2)
            lk <= wdata_i[0];
         if (wc && pend == 2'h1 && lk)
            code <= wdata_i;
      end
   end
   sequence s_cmd(logic [7:0] op); wc && idle && wdata_i == op; endsequence
   sequence s_last; wc && pend == 2'h1; endsequence
   property p_b1; s_cmd(8'h26) |=> !rom_bank_o; endproperty
   property p_b2; s_cmd(8'h27) |=> rom_bank_o; endproperty
   property p_nirq; s_cmd(8'h26) or s_cmd(8'h27) |=> !$rose(irq_o); endproperty
   property p_win;
      $past(reset_n_i, 3) && $past(reset_n_i, 2) && $past(reset_n_i)
         |-> rom_window_o == $past(win_sw_i, 3);
   endproperty
   property p_inf;
      rd_i && addr_i == 8'h04 && sends == 2'h2 |=> rdata_o[7:4] == 4'h0 && rdata_o[2:0] == 3'h0;
   endproperty
   property p_lk; s_last ##0 lk |=> !mbox_init_en_o; endproperty
   property p_keep;
      s_last ##0 (!lk && !mbox_init_en_o && wdata_i != code) |=> !mbox_init_en_o;
   endproperty
   property p_init; s_cmd(8'h01) |=> mbox_init_o == $past(mbox_init_en_o); endproperty
   a_b1: assert property (p_b1) else $error("bank one");
   a_b2: assert property (p_b2) else $error("bank two");
   a_nirq: assert property (p_nirq) else $error("bank irq");
   a_win: assert property (p_win) else $error("window");
   a_inf: assert property (p_inf) else $error("info zero bits");
   a_lk: assert property (p_lk) else $error("lock");
   a_keep: assert property (p_keep) else $error("wrong code unlocked");
   a_init: assert property (p_init) else $error("mailbox init");
endmodule : bbml_core_chk
bind bbml_core bbml_core_chk chk
(
   .clk_i(clk_i),
   .reset_n_i(reset_n_i),
   .addr_i(addr_i),
   .wdata_i(wdata_i),
   .wr_i(wr_i),
   .rd_i(rd_i),
   .rdata_o(rdata_o),
   .win_sw_i(win_sw_i),
   .rom_window_o(rom_window_o),
   .rom_bank_o(rom_bank_o),
   .mbox_init_en_o(mbox_init_en_o),
   .mbox_init_o(mbox_init_o),
   .irq_o(irq_o)
);
`default_nettype wire

// File: bench/test_bios_bank_and_mailbox_lock.sv
`timescale 1ns/10ps
`default_nettype none
module test_bios_bank_and_mailbox_lock;
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [2:0] win_sw_i = 3'h5;
   logic [7:0] rdata_o;
   logic [2:0] rom_window_o;
   logic rom_bank_o;
   logic mbox_init_en_o;
   logic mbox_init_o;
   logic irq_o;
   logic [14:0] ra;
   logic [7:0] d;
   logic [7:0] rsv [2] = '{8'h25, 8'h82};
   int fail_count = 0;
   int comparisons = 0;
   bbml_core dut
   (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .addr_i(addr_i),
      .wdata_i(wdata_i),
      .wr_i(wr_i),
      .rd_i(rd_i),
      .rdata_o(rdata_o),
      .win_sw_i(win_sw_i),
      .rom_window_o(rom_window_o),
      .rom_bank_o(rom_bank_o),
      .mbox_init_en_o(mbox_init_en_o),
      .mbox_init_o(mbox_init_o),
      .irq_o(irq_o)
   );
   bbml_rom_map rom (.bank_i(rom_bank_o), .offset_i(14'h0123), .rom_addr_o(ra));
   initial
   begin
      forever #12.5 clk_i = ~clk_i;
   end
   ////////////////////////////////////////////////////////////
   task automatic test_done;
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : test_done
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e)
      begin
         fail_count++;
         $display("[FAIL] %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= v;
      @(posedge clk_i);
      wr_i <= 1'b0;
      #1;
   endtask : wr
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask : rd
   task automatic rc(input string n, input logic [7:0] a, input logic [7:0] e);
      rd(a);
      chk(n, e, d);
   endtask : rc
   // flags read, then cleared by writing ones
   task automatic fl(input logic [7:0] e);
      rc("flags", 8'h0C, e);
      wr(8'h0C, 8'hFF);
   endtask : fl
   // poll data-in full, bounded so a stuck sequencer ends the run
   task automatic wt;
      for (int i = 0; i < 16; i++)
      begin
         rd(8'h08);
         if (d[0] === 1'b1)
            return;
      end
      chk("timeout", 8'h01, 8'h00);
      test_done;
   endtask : wt
   task automatic info(input logic [7:0] e0, input logic [7:0] e1);
      wr(8'h00, 8'h28);
      wt;
      rc("info0", 8'h04, e0);
      wt;
      rc("info1", 8'h04, e1);
   endtask : info
   task automatic lock(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] en);
      wr(8'h00, 8'h29);
      wr(8'h00, b0);
      wr(8'h00, b1);
      chk("init_en", en, {7'h00, mbox_init_en_o});
      fl(8'h81);
   endtask : lock
   ////////////////////////////////////////////////////////////
   initial
   begin
      repeat (4) @(posedge clk_i);
      reset_n_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      #1;
      chk("window", 8'h05, {5'h00, rom_window_o});
      chk("rom", 8'h02, ra[14:7]);
      wr(8'h10, 8'h7F);
      wr(8'h00, 8'h27);
      chk("rom", 8'h82, ra[14:7]);
      fl(8'h01);
      wr(8'h00, 8'h26);
      chk("rom", 8'h02, ra[14:7]);
      fl(8'h01);
      chk("irq", 8'h00, {7'h00, irq_o});
      wr(8'h14, 8'h01);
      info(8'h08, 8'h00);
      chk("irq", 8'h01, {7'h00, irq_o});
      fl(8'h81);
      lock(8'h01, 8'h02, 8'h00);
      rc("state", 8'h18, 8'h05);
      wr(8'h14, 8'h00);
      info(8'h00, 8'h02);
      fl(8'h81);
      wr(8'h00, 8'h01);
      chk("init", 8'h00, {7'h00, mbox_init_o});
      fl(8'h82);
      lock(8'h00, 8'h03, 8'h00);
      lock(8'h00, 8'h02, 8'h01);
      wr(8'h00, 8'h01);
      chk("init", 8'h01, {7'h00, mbox_init_o});
      fl(8'h85);
      foreach (rsv[i])
      begin
         wr(8'h00, rsv[i]);
         chk("irq", 8'h01, {7'h00, irq_o});
         fl(8'h82);
      end
      lock(8'h01, 8'h01, 8'h00);
      @(posedge clk_i);
      win_sw_i <= 3'h2;
      wr(8'h00, 8'h27);
      // mid-run reset must bring back bank one and unlock
      @(posedge clk_i);
      reset_n_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      reset_n_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      #1;
      chk("rom", 8'h02, ra[14:7]);
      chk("window", 8'h02, {5'h00, rom_window_o});
      chk("init_en", 8'h01, {7'h00, mbox_init_en_o});
      wr(8'h10, 8'h00);
      wr(8'h00, 8'h25);
      chk("irq", 8'h00, {7'h00, irq_o});
      rc("unmapped", 8'h1C, 8'h00);
      test_done;
   end
endmodule : test_bios_bank_and_mailbox_lock
`default_nettype wire
